/* src/tpb_pkg.sv */
package tpb_pkg;
    // switching period in clocks, a multiple of six
    localparam int          PERIOD_DEF   = 60;
    localparam int          CNT_W        = 16;
    localparam int          CUR_W        = 12;
    localparam int          MV_W         = 12;
    // reference levels in millivolts
    localparam logic [11:0] REF_MV_00    = 12'h258;
    localparam logic [11:0] REF_MV_01    = 12'h384;
    localparam logic [11:0] REF_MV_10    = 12'h4B0;
    localparam logic [11:0] REF_MV_11    = 12'h5DC;
    localparam logic [11:0] REF_HEAD_MV  = 12'h12C;
    // balance filter: error shift per cycle
    localparam int          FILT_SHIFT   = 2;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             ph1;
        logic             ph2;
        logic             win1;
        logic             win2;
        logic [CUR_W-1:0] smp1;
        logic [CUR_W-1:0] smp2;
        logic [CUR_W-1:0] avg;
        logic signed [CUR_W:0] corr1;
        logic signed [CUR_W:0] corr2;
        logic [MV_W-1:0]  target;
        logic             two_ph;
        logic             ug1;
        logic             lg1;
        logic             ug2;
        logic             lg2;
    } tpb_state_s;
endpackage

/* src/tpb_top.sv */
// Operation
// - two channels run unless single-channel mode is selected.
// - cycle starts when period clock drives phase one low.
// - phase two terminates half a period after phase one.
// - falling pulse turns upper off, lower on; rising the reverse.
// - pulse held low at least one third of a period.
// - after off-time, pulse rises when corrected error level crosses ramp.
// - high pulse stays high until its next termination.
// - grounded phase-count select gives single channel, second inactive.
// - each cycle sample active currents, sum, divide by active count.
// - per channel filtered sample-average difference trims pulse width.
// - sample window opens one sixth after fall, closes on rise.
// - sample at window close is held for the cycle average and balancing.
// - reference select 00..11 gives 0.6, 0.9, 1.2, 1.5 V.
// - target is lesser of applied reference and decoded plus 300 mV.
// - each channel duty is limited to 66 percent.
module tpb_top #(
    parameter int PERIOD = tpb_pkg::PERIOD_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     phase_count_select,
    input  wire logic                     ref_select_low_bit,
    input  wire logic                     ref_select_high_bit,
    input  wire logic [tpb_pkg::MV_W-1:0] applied_ref_mv,
    input  wire logic [tpb_pkg::MV_W-1:0] error_amp_level,
    input  wire logic [tpb_pkg::CUR_W-1:0] channel_current_sense_1,
    input  wire logic [tpb_pkg::CUR_W-1:0] channel_current_sense_2,
    output logic                          phase_one_pulse,
    output logic                          phase_two_pulse,
    output logic                          upper_gate_drive_1,
    output logic                          lower_gate_drive_1,
    output logic                          upper_gate_drive_2,
    output logic                          lower_gate_drive_2,
    output logic                          sample_window_1,
    output logic                          sample_window_2,
    output logic [tpb_pkg::CUR_W-1:0]     cycle_average_current,
    output logic [tpb_pkg::MV_W-1:0]      regulation_target_mv
);
    localparam int CW = tpb_pkg::CNT_W;
    localparam logic [CW-1:0] P_LAST  = CW'(PERIOD - 1);
    localparam logic [CW-1:0] P_HALF  = CW'(PERIOD / 2);
    localparam logic [CW-1:0] P_THIRD = CW'(PERIOD / 3);
    localparam logic [CW-1:0] P_SIXTH = CW'(PERIOD / 6);

    // pin inputs pass two flops; analog levels arrive as sampled words
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [tpb_pkg::CUR_W-1:0] cs1_meta_reg;
    logic [tpb_pkg::CUR_W-1:0] cs1_sync_reg;
    logic [tpb_pkg::CUR_W-1:0] cs2_meta_reg;
    logic [tpb_pkg::CUR_W-1:0] cs2_sync_reg;
    logic [tpb_pkg::MV_W-1:0]  ea_meta_reg;
    logic [tpb_pkg::MV_W-1:0]  ea_sync_reg;
    logic [tpb_pkg::MV_W-1:0]  ar_meta_reg;
    logic [tpb_pkg::MV_W-1:0]  ar_sync_reg;

    // synchronisers: first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            cs1_meta_reg <= '0;
            cs1_sync_reg <= '0;
            cs2_meta_reg <= '0;
            cs2_sync_reg <= '0;
            ea_meta_reg  <= '0;
            ea_sync_reg  <= '0;
            ar_meta_reg  <= '0;
            ar_sync_reg  <= '0;
        end else begin
            pin_meta_reg <= {ref_select_high_bit, ref_select_low_bit,
                             phase_count_select};
            pin_sync_reg <= pin_meta_reg;
            cs1_meta_reg <= channel_current_sense_1;
            cs1_sync_reg <= cs1_meta_reg;
            cs2_meta_reg <= channel_current_sense_2;
            cs2_sync_reg <= cs2_meta_reg;
            ea_meta_reg  <= error_amp_level;
            ea_sync_reg  <= ea_meta_reg;
            ar_meta_reg  <= applied_ref_mv;
            ar_sync_reg  <= ar_meta_reg;
        end
    end

    tpb_pkg::tpb_state_s s_reg;
    tpb_pkg::tpb_state_s s_next;

    logic [CW-1:0] off1;
    logic [CW-1:0] off2;
    logic [CW-1:0] ramp1;
    logic [CW-1:0] ramp2;
    logic signed [CW+1:0] lvl1;
    logic signed [CW+1:0] lvl2;
    logic [tpb_pkg::MV_W-1:0] dac_mv;
    logic [tpb_pkg::MV_W-1:0] dac_head;
    logic [tpb_pkg::CUR_W:0]  sum;
    logic signed [tpb_pkg::CUR_W+1:0] err1;
    logic signed [tpb_pkg::CUR_W+1:0] err2;
    logic term1;
    logic term2;

    // phase-relative counters and ramps
    always_comb begin
        off1 = s_reg.cnt;
        off2 = (s_reg.cnt >= P_HALF) ? s_reg.cnt - P_HALF
                                     : s_reg.cnt + P_HALF;
        // ramp spans the on-enable part of the cycle (last two thirds)
        ramp1 = (off1 >= P_THIRD) ? off1 - P_THIRD : '0;
        ramp2 = (off2 >= P_THIRD) ? off2 - P_THIRD : '0;
        lvl1 = $signed({2'b00, CW'(ea_sync_reg)}) - (CW+2)'(s_reg.corr1);
        lvl2 = $signed({2'b00, CW'(ea_sync_reg)}) - (CW+2)'(s_reg.corr2);
        term1 = (s_reg.cnt == P_LAST);
        term2 = (s_reg.cnt == P_HALF - CW'(1));
    end

    // reference decode and clamp
    always_comb begin
        unique case ({pin_sync_reg[2], pin_sync_reg[1]})
            2'b00: dac_mv = tpb_pkg::REF_MV_00;
            2'b01: dac_mv = tpb_pkg::REF_MV_01;
            2'b10: dac_mv = tpb_pkg::REF_MV_10;
            2'b11: dac_mv = tpb_pkg::REF_MV_11;
        endcase
        dac_head = dac_mv + tpb_pkg::REF_HEAD_MV;
    end

    // balancing arithmetic
    always_comb begin
        sum = s_reg.two_ph ? ({1'b0, s_reg.smp1} + {1'b0, s_reg.smp2})
                           : {1'b0, s_reg.smp1};
        err1 = $signed({2'b00, s_reg.smp1}) - $signed({2'b00, s_reg.avg});
        err2 = $signed({2'b00, s_reg.smp2}) - $signed({2'b00, s_reg.avg});
    end

    // whole next state; cycles end on fixed counts so no extra sync needed
    always_comb begin
        s_next = s_reg;
        s_next.cnt = term1 ? '0 : s_reg.cnt + CW'(1);
        s_next.two_ph = pin_sync_reg[0];
        s_next.target = (ar_sync_reg < dac_head) ? ar_sync_reg
                                                 : dac_head;
        // phase one: fall on termination, rise after off-time on crossing
        if (term1) begin
            s_next.ph1 = 1'b0;
        end else if (!s_reg.ph1 && off1 >= P_THIRD
                     && lvl1 > $signed({2'b00, ramp1})) begin
            s_next.ph1 = 1'b1;
        end
        if (!s_reg.two_ph || term2) begin
            s_next.ph2 = 1'b0;
        end else if (!s_reg.ph2 && off2 >= P_THIRD
                     && lvl2 > $signed({2'b00, ramp2})) begin
            s_next.ph2 = 1'b1;
        end
        // sample window open from one sixth after fall until rise
        s_next.win1 = !s_next.ph1 && (off1 + CW'(1) >= P_SIXTH)
                      && !term1;
        s_next.win2 = s_reg.two_ph && !s_next.ph2 && !term2
                      && (off2 + CW'(1) >= P_SIXTH);
        // capture on window close, hold otherwise; sample two is cleared in single-channel mode
        if (s_reg.win1 && !s_next.win1) begin
            s_next.smp1 = cs1_sync_reg;
        end
        if (!s_reg.two_ph) begin
            s_next.smp2 = '0;
        end else if (s_reg.win2 && !s_next.win2) begin
            s_next.smp2 = cs2_sync_reg;
        end
        // average and filtered correction once per cycle
        if (term1) begin
            s_next.avg = s_reg.two_ph ? sum[tpb_pkg::CUR_W:1]
                                      : sum[tpb_pkg::CUR_W-1:0];
            s_next.corr1 = s_reg.corr1
                + (tpb_pkg::CUR_W+1)'(err1 >>> tpb_pkg::FILT_SHIFT)
                - (tpb_pkg::CUR_W+1)'(s_reg.corr1 >>> tpb_pkg::FILT_SHIFT);
            s_next.corr2 = !s_reg.two_ph ? '0 : s_reg.corr2
                + (tpb_pkg::CUR_W+1)'(err2 >>> tpb_pkg::FILT_SHIFT)
                - (tpb_pkg::CUR_W+1)'(s_reg.corr2 >>> tpb_pkg::FILT_SHIFT);
        end
        // drivers follow the pulses, never both on
        s_next.ug1 = s_next.ph1;
        s_next.lg1 = !s_next.ph1;
        s_next.ug2 = s_next.ph2;
        s_next.lg2 = !s_next.ph2 && s_reg.two_ph;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign phase_one_pulse       = s_reg.ph1;
    assign phase_two_pulse       = s_reg.ph2;
    assign upper_gate_drive_1    = s_reg.ug1;
    assign lower_gate_drive_1    = s_reg.lg1;
    assign upper_gate_drive_2    = s_reg.ug2;
    assign lower_gate_drive_2    = s_reg.lg2;
    assign sample_window_1       = s_reg.win1;
    assign sample_window_2       = s_reg.win2;
    assign cycle_average_current = s_reg.avg;
    assign regulation_target_mv  = s_reg.target;

    property p_ph1_fall;
        @(posedge clk) disable iff (rst)
        s_reg.cnt == P_LAST |=> !phase_one_pulse;
    endproperty
    a_ph1_fall: assert property (p_ph1_fall) else $error("ph1 not low");

    property p_ph2_fall;
        @(posedge clk) disable iff (rst)
        s_reg.cnt == P_HALF - CW'(1) |=> !phase_two_pulse;
    endproperty
    a_ph2_fall: assert property (p_ph2_fall) else $error("ph2 not low");

    property p_gates;
        @(posedge clk) disable iff (rst)
        !(upper_gate_drive_1 && lower_gate_drive_1)
        && (upper_gate_drive_1 == phase_one_pulse);
    endproperty
    a_gates: assert property (p_gates) else $error("gate mismatch");

    // low-run length of phase one, only for the off-time check;
    // a counter because the off-time scales with the period
    logic [CW-1:0] low_run_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run_reg <= '0;
        end else if (phase_one_pulse) begin
            low_run_reg <= '0;
        end else if (low_run_reg != '1) begin
            low_run_reg <= low_run_reg + CW'(1);
        end
    end

    property p_offtime;
        @(posedge clk) disable iff (rst)
        $rose(phase_one_pulse) |-> $past(low_run_reg) >= P_THIRD;
    endproperty
    a_offtime: assert property (p_offtime) else $error("off too short");

    property p_no_early_rise;
        @(posedge clk) disable iff (rst)
        $rose(phase_one_pulse) |-> $past(s_reg.cnt) >= P_THIRD;
    endproperty
    a_no_early_rise: assert property (p_no_early_rise)
        else $error("rise in off-time");

    property p_stay_high;
        @(posedge clk) disable iff (rst)
        phase_one_pulse && s_reg.cnt != P_LAST |=> phase_one_pulse;
    endproperty
    a_stay_high: assert property (p_stay_high) else $error("ph1 dropped");

    property p_single;
        @(posedge clk) disable iff (rst)
        !s_reg.two_ph |=> !phase_two_pulse && !sample_window_2;
    endproperty
    a_single: assert property (p_single) else $error("ch2 active");

    property p_window;
        @(posedge clk) disable iff (rst)
        sample_window_1 |-> !phase_one_pulse && s_reg.cnt >= P_SIXTH;
    endproperty
    a_window: assert property (p_window) else $error("window early");

    property p_target;
        @(posedge clk) disable iff (rst)
        ##1 regulation_target_mv <= $past(dac_head);
    endproperty
    a_target: assert property (p_target) else $error("target high");

    property p_gates2;
        @(posedge clk) disable iff (rst)
        !(upper_gate_drive_2 && lower_gate_drive_2)
        && (upper_gate_drive_2 == phase_two_pulse);
    endproperty
    a_gates2: assert property (p_gates2) else $error("gate2 mismatch");

    property p_stay_high2;
        @(posedge clk) disable iff (rst)
        phase_two_pulse && s_reg.two_ph && s_reg.cnt != P_HALF - CW'(1)
        |=> phase_two_pulse;
    endproperty
    a_stay_high2: assert property (p_stay_high2)
        else $error("ph2 dropped");

    property p_window2;
        @(posedge clk) disable iff (rst)
        sample_window_2 |-> !phase_two_pulse && off2 >= P_SIXTH;
    endproperty
    a_window2: assert property (p_window2) else $error("window2 early");

    // single mode: average is the phase-one sample alone
    property p_avg_single;
        @(posedge clk) disable iff (rst)
        s_reg.cnt == P_LAST && !s_reg.two_ph
        |=> cycle_average_current == $past(s_reg.smp1);
    endproperty
    a_avg_single: assert property (p_avg_single)
        else $error("single average wrong");

    c_ph1_rise: cover property (@(posedge clk) $rose(phase_one_pulse));
    c_ph2_rise: cover property (@(posedge clk) $rose(phase_two_pulse));
    c_sample:   cover property (@(posedge clk) $fell(sample_window_1));
    c_single:   cover property (@(posedge clk) !s_reg.two_ph && s_reg.ph1);
endmodule

/* verification/tpb_far_side.sv */
// stand-in for the power stages and the lower-switch current sense
module tpb_far_side (
    input  wire logic        clk,
    input  wire logic        upper_1,
    input  wire logic        lower_1,
    input  wire logic        upper_2,
    input  wire logic        lower_2,
    input  wire logic [11:0] load_1,
    input  wire logic [11:0] load_2,
    output logic      [11:0] sense_1,
    output logic      [11:0] sense_2,
    output logic             shoot_through
);
    timeunit 1ns;
    timeprecision 1ps;
    // sense is valid only while the lower switch conducts;
    // otherwise show a wrong word so a mistimed sample is visible
    assign sense_1 = lower_1 ? load_1 : ~load_1;
    assign sense_2 = lower_2 ? load_2 : ~load_2;
    // both switches of one leg on at once would short the input rail
    initial shoot_through = 1'b0;
    always @(posedge clk) begin
        if ((upper_1 && lower_1) || (upper_2 && lower_2)) begin
            shoot_through <= 1'b1;
        end
    end
endmodule

/* verification/tpb_top_bench.sv */
module tpb_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // short period keeps the run brief; still a multiple of six
    localparam int P = 12;
    logic        clk, rst, sel, r_lo, r_hi, ph1, ph2;
    logic        ug1, lg1, ug2, lg2, w1, w2, fault;
    logic [11:0] ref_mv, lvl, cur1, cur2, s1, s2, avg, tgt;
    int          failures, n_compared;

    tpb_top #(.PERIOD(P)) u_dut (
        .clk(clk), .rst(rst), .phase_count_select(sel),
        .ref_select_low_bit(r_lo), .ref_select_high_bit(r_hi),
        .applied_ref_mv(ref_mv), .error_amp_level(lvl),
        .channel_current_sense_1(s1), .channel_current_sense_2(s2),
        .phase_one_pulse(ph1), .phase_two_pulse(ph2),
        .upper_gate_drive_1(ug1), .lower_gate_drive_1(lg1),
        .upper_gate_drive_2(ug2), .lower_gate_drive_2(lg2),
        .sample_window_1(w1), .sample_window_2(w2),
        .cycle_average_current(avg), .regulation_target_mv(tgt));

    tpb_far_side u_far (
        .clk(clk), .upper_1(ug1), .lower_1(lg1), .upper_2(ug2),
        .lower_2(lg2), .load_1(cur1), .load_2(cur2), .sense_1(s1),
        .sense_2(s2), .shoot_through(fault));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("compared %0d, wrong %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int s);
        if (s == 0) return ph1;
        if (s == 1) return ph2;
        if (s == 2) return w1;
        return w2;
    endfunction

    // counts edges until the chosen output reaches v; bounded
    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v) begin
            cyc(1);
            n++;
            if (n > 4 * P) begin
                failures++;
                results();
            end
        end
    endtask

    // align to the edge where phase one terminates
    task automatic sync();
        int n;
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
    endtask

    task automatic t_ref();
        logic [11:0] dac [4];
        logic [11:0] app [2];
        logic [11:0] cap;
        dac = '{12'h258, 12'h384, 12'h4B0, 12'h5DC};
        app = '{12'hFFF, 12'h500};
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 2; j++) begin
                @(negedge clk);
                {r_hi, r_lo} = i[1:0];
                ref_mv = app[j];
                cyc(6);
                cap = dac[i] + 12'h12C;
                chk(tgt, (app[j] < cap) ? app[j] : cap);
            end
        end
    endtask

    task automatic t_timing();
        int n, m;
        sync();
        wait_for(2, 1'b1, n);
        chk(n[15:0], 16'(P / 6));
        sync();
        wait_for(0, 1'b1, n);
        chk(16'(n >= P / 3), 16'h1);
        chk({ug1, lg1, w1}, 16'h4);
        wait_for(0, 1'b0, m);
        chk(16'(n + m), 16'(P));
        chk({ug1, lg1}, 16'h1);
        sync();
        wait_for(1, 1'b0, n);
        chk(n[15:0], 16'(P / 2));
        chk({ug2, lg2}, 16'h1);
        wait_for(3, 1'b1, n);
        chk(n[15:0], 16'(P / 6));
    endtask

    // with the error level at zero the ramp is never crossed
    task automatic t_no_cross();
        int k;
        @(negedge clk);
        lvl = 12'h000;
        cyc(2 * P);
        k = 0;
        repeat (P) begin
            cyc(1);
            k += ph1;
        end
        chk(k[15:0], 16'h0);
        @(negedge clk);
        lvl = 12'hFFF;
        cyc(2 * P);
    endtask

    task automatic t_avg();
        int k;
        @(negedge clk);
        cur1 = 12'h100;
        cur2 = 12'h300;
        cyc(4 * P);
        chk(avg, 12'h200);
        @(negedge clk);
        sel = 1'b0;
        cyc(4 * P);
        chk(avg, 12'h100);
        k = 0;
        repeat (2 * P) begin
            cyc(1);
            k += ph2 | ug2 | lg2 | w2;
        end
        chk(k[15:0], 16'h0);
        chk(fault, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        sel = 1'b1;
        {r_hi, r_lo} = 2'b00;
        ref_mv = 12'hFFF;
        lvl = 12'hFFF;
        cur1 = 12'h200;
        cur2 = 12'h200;
        failures = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cyc(4 * P);
        t_ref();
        t_timing();
        t_no_cross();
        t_avg();
        results();
    end
endmodule
